// ==== src/ovsm_consts.svh ====
// Register indices, field positions, reset values and ramp timing constants
`ifndef OVSM_CONSTS_SVH
`define OVSM_CONSTS_SVH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define OVSM_IDX_FILT1 14'h0410
`define OVSM_IDX_LC1 14'h0440
`define OVSM_IDX_LC2 14'h0540
`define OVSM_IDX_DAC_L 14'h0610
`define OVSM_IDX_DAC_R 14'h0611
`define OVSM_IDX_TX_L 14'h0612
`define OVSM_IDX_TX_R 14'h0613
`define OVSM_IDX_SOFTMUTE 14'h0614
`define OVSM_IDX_STATUS 14'h0620
// ----------------------------------------
// Field positions
// ----------------------------------------
`define OVSM_BIT_MUTE 9
`define OVSM_BIT_COMMIT 8
`define OVSM_BIT_QUAD 15
`define OVSM_BIT_SPEED 0
`define OVSM_BIT_UNMUTE_SEL 1
`define OVSM_BIT_LC_PLAY 2
`define OVSM_BIT_LC_RECL 1
`define OVSM_BIT_LC_RECR 0
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define OVSM_RST_VOL 8'hC0
`define OVSM_RST_MUTE 4'hF
`define OVSM_RST_FILT 16'h0000
`define OVSM_RST_LC 3'h0
`define OVSM_CODE_UNITY 8'hC0
`define OVSM_CODE_MAX 8'hE0
// ----------------------------------------
// Ramp timing
// ----------------------------------------
`define OVSM_FAST_DIV 6'h02
`define OVSM_SLOW_DIV 6'h20
`define OVSM_REF_FS_HZ 48000.0
`define OVSM_FAST_MAX_MS 10.7
`define OVSM_SLOW_MAX_MS 171.0
`endif

// ==== src/ovsm_pkg.sv ====
// Types shared by the output volume and soft mute block
package ovsm_pkg;
  typedef enum logic [2:0] {
    OVSM_LIVE = 3'b001,
    OVSM_DOWN = 3'b010,
    OVSM_UP = 3'b100
  } ovsm_ramp_e;
  typedef logic [7:0] ovsm_code_t;
  typedef struct packed {
    ovsm_ramp_e mode;
    ovsm_code_t level;
  } ovsm_ramp_s;
  typedef struct packed {
    logic [15:0] filt1;
    logic [2:0] lc1;
    logic [2:0] lc2;
    logic [3:0] mute;
    logic [3:0][7:0] stored;
    logic [3:0][7:0] active;
    logic unmute_sel;
    logic speed;
    logic [4:0] tick_cnt;
    logic tick;
    logic ap_valid;
    logic ap_write;
    logic [13:0] ap_idx;
    logic [31:0] rdata;
    logic [5:0] lc_out;
    logic quad_out;
    logic out_valid;
  } ovsm_regs_s;
endpackage

// ==== src/ovsm_ramp.sv ====
// Per-path soft mute and unmute gain ramp
`include "ovsm_consts.svh"
module ovsm_ramp (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Control
  input wire logic tick,
  input wire logic mute,
  input wire logic unmute_ramp,
  input wire ovsm_pkg::ovsm_code_t target,
  // Applied code
  output ovsm_pkg::ovsm_code_t level
);
  import ovsm_pkg::*;
  ovsm_ramp_s q, next_q;
  ovsm_code_t tgt;
  assign tgt = (target >= `OVSM_CODE_MAX) ? `OVSM_CODE_MAX : target;
  assign level = q.level;
  always_comb begin
    next_q = q;
    case (q.mode)
      OVSM_LIVE: begin
        next_q.level = tgt;
        if (mute) next_q.mode = OVSM_DOWN; // RULE3
      end
      OVSM_DOWN: begin
        if (!mute) begin
          if (unmute_ramp) begin
            next_q.mode = OVSM_UP; // RULE4
          end else begin
            next_q.mode = OVSM_LIVE; // RULE4
            next_q.level = tgt;
          end
        end else if (tick && q.level != 8'h00) begin
          next_q.level = q.level - 8'h01; // RULE3 RULE21
        end
      end
      OVSM_UP: begin
        if (mute) begin
          next_q.mode = OVSM_DOWN;
        end else if (q.level == tgt) begin
          next_q.mode = OVSM_LIVE;
        end else if (tick) begin
          // One code per tick, so ramp time follows the distance
          next_q.level = (q.level < tgt) ? q.level + 8'h01 : q.level - 8'h01; // RULE7 RULE21
        end
      end
      default: begin
        next_q.mode = OVSM_DOWN;
        next_q.level = 8'h00;
      end
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{mode: OVSM_DOWN, level: 8'h00}; // RULE8
    end else if (ce) begin
      q <= next_q;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_mute_down;
    @(posedge hclk) disable iff (!hresetn)
    (ce && mute && q.mode == OVSM_DOWN && tick && q.level != 8'h00)
      |=> q.level == $past(q.level) - 8'h01;
  endproperty
  a_mute_down: assert property (p_mute_down) else $error("mute ramp did not step down"); // RULE3
  property p_instant;
    @(posedge hclk) disable iff (!hresetn)
    (ce && q.mode == OVSM_DOWN && !mute && !unmute_ramp) |=> q.level == $past(tgt);
  endproperty
  a_instant: assert property (p_instant) else $error("instant unmute missed target"); // RULE4
  property p_step;
    @(posedge hclk) disable iff (!hresetn)
    (ce && q.mode == OVSM_UP && !mute && !tick) |=> $stable(q.level);
  endproperty
  a_step: assert property (p_step) else $error("ramp moved without a tick"); // RULE21
  property p_hold_muted;
    @(posedge hclk) disable iff (!hresetn)
    (mute && q.level == 8'h00 && q.mode == OVSM_DOWN) |=> q.level == 8'h00;
  endproperty
  a_hold_muted: assert property (p_hold_muted) else $error("muted path leaked gain"); // RULE8
endmodule // ovsm_ramp

// ==== src/ovsm_gain.sv ====
// Applies an 8-bit volume code to one sample stream
`include "ovsm_consts.svh"
module ovsm_gain #(
  parameter int W = 24
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Samples
  input wire logic in_valid,
  input wire ovsm_pkg::ovsm_code_t code,
  input wire logic signed [W-1:0] sample_in,
  output logic signed [W-1:0] sample_out
);
  import ovsm_pkg::*;
  typedef struct packed {
    logic signed [W-1:0] sample;
  } ovsm_gain_s;
  // 2^(f/16) in Q1.15, one entry per 0.375 dB step within 6 dB
  localparam logic [15:0] MANT [16] = '{16'h8000, 16'h85AB, 16'h8B96, 16'h91C4,
    16'h9838, 16'h9EF5, 16'hA5FF, 16'hAD58, 16'hB505, 16'hBD09, 16'hC567,
    16'hCE25, 16'hD745, 16'hE0CD, 16'hEAC1, 16'hF525};
  localparam logic signed [W+16:0] SMAX = (W+17)'({1'b0, {(W-1){1'b1}}});
  localparam logic signed [W+16:0] SMIN = -SMAX - (W+17)'(1);
  ovsm_gain_s q, next_q;
  ovsm_code_t c;
  logic signed [W+16:0] prod;
  logic signed [W+16:0] scaled;
  logic [4:0] sh;
  if (W < 8) begin : g_bad_w
    $error("sample width too small");
  end
  assign c = (code >= `OVSM_CODE_MAX) ? `OVSM_CODE_MAX : code; // RULE1
  assign prod = (W+17)'(sample_in) * $signed({1'b0, MANT[c[3:0]]});
  assign sh = 5'd27 - {1'b0, c[7:4]};
  assign scaled = prod >>> sh;
  assign sample_out = q.sample;
  always_comb begin
    next_q = q;
    if (in_valid) begin
      if (code == 8'h00) begin
        next_q.sample = '0; // RULE1
      end else if (scaled > SMAX) begin
        next_q.sample = SMAX[W-1:0];
      end else if (scaled < SMIN) begin
        next_q.sample = SMIN[W-1:0];
      end else begin
        next_q.sample = scaled[W-1:0];
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_mute_code;
    @(posedge hclk) disable iff (!hresetn)
    (ce && in_valid && code == 8'h00) |=> sample_out == '0;
  endproperty
  a_mute_code: assert property (p_mute_code) else $error("code zero did not mute"); // RULE1
  property p_unity;
    @(posedge hclk) disable iff (!hresetn)
    (ce && in_valid && code == `OVSM_CODE_UNITY) |=> sample_out == $past(sample_in);
  endproperty
  a_unity: assert property (p_unity) else $error("unity code changed sample"); // RULE1
endmodule // ovsm_gain

// ==== src/ovsm_top.sv ====
// Output volume, soft mute, quad-rate and level control placement block
//
// Added by the designer: the AHB-Lite interface to the registers.
`include "ovsm_consts.svh"
// How it works
// RULE1: Code zero mutes, C0h unity, E0h up +12dB
// RULE2: Transmit commit bit applies both stored gains together
// RULE3: Mute lowers path gain gradually
// RULE4: Unmute instant or ramped per select bit
// RULE5: Ramp ticks at fs/2 fast, fs/32 slow
// RULE6: Ramp rate follows sample rate, bounded time
// RULE7: Ramp time proportional to level distance
// RULE8: Paths reset soft-muted; host clears mute
// RULE9: One speed and select bit for all
// RULE10: Quad-rate bit runs record one at 4fs
// RULE11: Host uses quad-rate only as port master
// RULE12: Quad-rate bypasses record filters and volume
// RULE13: Quad-rate drops record level control, playback kept
// RULE14: Two level controllers, playback or record each
// RULE15: Host never enables playback and record together
// RULE16: Host enables record high-pass with level control
// RULE17: Port one playback level enable, resets off
// RULE18: Per-path mute bit nine, resets set
// RULE19: Volume write stores only until commit
// RULE20: Port two playback, left, right enables
// RULE21: Ramp moves one code per tick
module ovsm_top #(
  parameter int W = 24
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Sample inputs from the mixers
  input wire logic sample_valid,
  input wire logic signed [W-1:0] dac_left_in,
  input wire logic signed [W-1:0] dac_right_in,
  input wire logic signed [W-1:0] tx_two_left_in,
  input wire logic signed [W-1:0] tx_two_right_in,
  // Scaled sample outputs
  output logic out_valid,
  output logic signed [W-1:0] dac_left_out,
  output logic signed [W-1:0] dac_right_out,
  output logic signed [W-1:0] tx_two_left_out,
  output logic signed [W-1:0] tx_two_right_out,
  // Port one record path controls
  output logic record_one_quad_rate,
  output logic rec_one_filter_bypass,
  output logic rec_one_volume_bypass,
  // Level controller placement
  output logic play_one_level_ctrl_enable,
  output logic rec_one_left_level_ctrl,
  output logic rec_one_right_level_ctrl,
  output logic play_two_level_ctrl_enable,
  output logic rec_two_left_level_ctrl,
  output logic rec_two_right_level_ctrl
);
  import ovsm_pkg::*;
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  localparam real FAST_MS = 224.0 * 2.0 * 1000.0 / `OVSM_REF_FS_HZ;
  localparam real SLOW_MS = 224.0 * 32.0 * 1000.0 / `OVSM_REF_FS_HZ;
  if (W < 8 || W > 32) begin : g_bad_w
    $error("sample width out of range");
  end
  if (FAST_MS > `OVSM_FAST_MAX_MS || SLOW_MS > `OVSM_SLOW_MAX_MS) begin : g_bad_ramp
    $error("ramp divider too slow"); // RULE6
  end

  ovsm_regs_s s, next_s;
  logic [3:0][7:0] level;
  logic [3:0][W-1:0] path_in;
  logic [3:0][W-1:0] path_out;
  logic addr_take;

  assign path_in = {tx_two_right_in, tx_two_left_in, dac_right_in, dac_left_in};
  assign dac_left_out = path_out[0];
  assign dac_right_out = path_out[1];
  assign tx_two_left_out = path_out[2];
  assign tx_two_right_out = path_out[3];

  // ----------------------------------------
  // Bus outputs
  // ----------------------------------------
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign addr_take = hsel && hready && htrans[1] && ce;

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  assign out_valid = s.out_valid;
  assign record_one_quad_rate = s.quad_out;
  assign rec_one_filter_bypass = s.quad_out;
  assign rec_one_volume_bypass = s.quad_out;
  assign play_one_level_ctrl_enable = s.lc_out[5];
  assign rec_one_left_level_ctrl = s.lc_out[4];
  assign rec_one_right_level_ctrl = s.lc_out[3];
  assign play_two_level_ctrl_enable = s.lc_out[2];
  assign rec_two_left_level_ctrl = s.lc_out[1];
  assign rec_two_right_level_ctrl = s.lc_out[0];

  // ----------------------------------------
  // Register read value
  // ----------------------------------------
  function automatic logic [31:0] read_reg(input ovsm_regs_s r, input logic [13:0] idx,
                                           input logic [3:0][7:0] lvl);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (idx)
      `OVSM_IDX_FILT1: v = {16'h0000, r.filt1};
      `OVSM_IDX_LC1: v = {29'h0, r.lc1};
      `OVSM_IDX_LC2: v = {29'h0, r.lc2};
      `OVSM_IDX_DAC_L: v = {22'h0, r.mute[0], 1'b0, r.stored[0]};
      `OVSM_IDX_DAC_R: v = {22'h0, r.mute[1], 1'b0, r.stored[1]};
      `OVSM_IDX_TX_L: v = {22'h0, r.mute[2], 1'b0, r.stored[2]};
      `OVSM_IDX_TX_R: v = {22'h0, r.mute[3], 1'b0, r.stored[3]};
      `OVSM_IDX_SOFTMUTE: v = {30'h0, r.unmute_sel, r.speed};
      `OVSM_IDX_STATUS: v = lvl;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [5:0] div;
    logic [1:0] pair;
    div = 6'h00;
    pair = 2'h0;
    next_s = s;
    // Register writes in the data phase
    if (s.ap_valid && s.ap_write) begin
      case (s.ap_idx)
        `OVSM_IDX_FILT1: next_s.filt1 = hwdata[15:0]; // RULE10
        `OVSM_IDX_LC1: next_s.lc1 = hwdata[2:0]; // RULE17
        `OVSM_IDX_LC2: next_s.lc2 = hwdata[2:0]; // RULE20
        `OVSM_IDX_SOFTMUTE: begin
          next_s.speed = hwdata[`OVSM_BIT_SPEED]; // RULE9
          next_s.unmute_sel = hwdata[`OVSM_BIT_UNMUTE_SEL]; // RULE9
        end
        default: begin
        end
      endcase
      for (int i = 0; i < 4; i++) begin
        if (s.ap_idx == `OVSM_IDX_DAC_L + 14'(i)) begin
          next_s.stored[i] = hwdata[7:0]; // RULE19
          next_s.mute[i] = hwdata[`OVSM_BIT_MUTE]; // RULE18
          if (hwdata[`OVSM_BIT_COMMIT]) begin
            // Both channels of the pair change together
            pair = 2'(i & 2);
            next_s.active[pair] = next_s.stored[pair]; // RULE2
            next_s.active[pair + 2'h1] = next_s.stored[pair + 2'h1]; // RULE2
          end
        end
      end
    end
    // Address phase capture
    next_s.ap_valid = addr_take;
    if (addr_take) begin
      next_s.ap_write = hwrite;
      next_s.ap_idx = haddr[15:2];
      next_s.rdata = hwrite ? 32'h0000_0000 : read_reg(next_s, haddr[15:2], level);
    end
    // Ramp tick, counted in samples so it scales with fs
    div = s.speed ? `OVSM_SLOW_DIV : `OVSM_FAST_DIV; // RULE5
    next_s.tick = 1'b0;
    if (sample_valid) begin
      // Counter runs 0..div-1, so the slow divide of 32 fits five bits
      if ({1'b0, s.tick_cnt} >= div - 6'h01) begin
        next_s.tick_cnt = 5'h00;
        next_s.tick = 1'b1; // RULE5 RULE6
      end else begin
        next_s.tick_cnt = s.tick_cnt + 5'h01;
      end
    end
    next_s.out_valid = sample_valid;
    // Level controller placement, port one record side dropped in quad-rate
    next_s.quad_out = next_s.filt1[`OVSM_BIT_QUAD]; // RULE10 RULE12
    next_s.lc_out[5] = next_s.lc1[`OVSM_BIT_LC_PLAY]; // RULE13 RULE14
    next_s.lc_out[4] = next_s.lc1[`OVSM_BIT_LC_RECL] && !next_s.quad_out; // RULE13
    next_s.lc_out[3] = next_s.lc1[`OVSM_BIT_LC_RECR] && !next_s.quad_out; // RULE13
    next_s.lc_out[2:0] = next_s.lc2; // RULE14 RULE20
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.filt1 <= `OVSM_RST_FILT;
      s.lc1 <= `OVSM_RST_LC; // RULE17
      s.lc2 <= `OVSM_RST_LC;
      s.mute <= `OVSM_RST_MUTE; // RULE8 RULE18
      s.stored <= {4{`OVSM_RST_VOL}};
      s.active <= {4{`OVSM_RST_VOL}};
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Per-path ramp and gain
  // ----------------------------------------
  for (genvar p = 0; p < 4; p++) begin : g_path
    ovsm_ramp u_ramp (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .tick(s.tick),
      .mute(s.mute[p]), // RULE3
      .unmute_ramp(s.unmute_sel), // RULE9
      .target(s.active[p]),
      .level(level[p])
    );
    ovsm_gain #(
      .W(W)
    ) u_gain (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .in_valid(sample_valid),
      .code(level[p]),
      .sample_in(path_in[p]),
      .sample_out(path_out[p])
    );
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_commit_tx;
    @(posedge hclk) disable iff (!hresetn)
    (ce && s.ap_valid && s.ap_write && s.ap_idx == `OVSM_IDX_TX_R && hwdata[8])
      |=> s.active[3] == s.stored[3] && s.active[2] == s.stored[2];
  endproperty
  a_commit_tx: assert property (p_commit_tx) else $error("tx pair not committed"); // RULE2
  property p_store_only;
    @(posedge hclk) disable iff (!hresetn)
    (ce && s.ap_valid && s.ap_write && s.ap_idx == `OVSM_IDX_DAC_L && !hwdata[8])
      |=> $stable(s.active);
  endproperty
  a_store_only: assert property (p_store_only) else $error("gain changed without commit"); // RULE19
  property p_tick_fast;
    @(posedge hclk) disable iff (!hresetn)
    (ce && !s.speed && sample_valid && s.tick_cnt == 5'h01) |=> s.tick;
  endproperty
  a_tick_fast: assert property (p_tick_fast) else $error("fast tick missing"); // RULE5
  property p_tick_slow;
    @(posedge hclk) disable iff (!hresetn)
    (ce && s.speed && sample_valid && s.tick_cnt < 5'h1F) |=> !s.tick;
  endproperty
  a_tick_slow: assert property (p_tick_slow) else $error("slow tick too early"); // RULE5
  property p_tick_slow_end;
    @(posedge hclk) disable iff (!hresetn)
    (ce && s.speed && sample_valid && s.tick_cnt == 5'h1F) |=> s.tick && s.tick_cnt == 5'h00;
  endproperty
  a_tick_slow_end: assert property (p_tick_slow_end) else $error("slow tick missing"); // RULE5
  property p_quad;
    @(posedge hclk) disable iff (!hresetn)
    s.quad_out |-> !rec_one_left_level_ctrl && !rec_one_right_level_ctrl
      && rec_one_volume_bypass && play_one_level_ctrl_enable == s.lc1[2];
  endproperty
  a_quad: assert property (p_quad) else $error("quad-rate record path not bypassed"); // RULE13
  property p_mute_write;
    @(posedge hclk) disable iff (!hresetn)
    (ce && s.ap_valid && s.ap_write && s.ap_idx == `OVSM_IDX_TX_L)
      |=> s.mute[2] == $past(hwdata[9]);
  endproperty
  a_mute_write: assert property (p_mute_write) else $error("mute bit not stored"); // RULE18
endmodule // ovsm_top

// ==== tb/ovsm_mixer_model.sv ====
// Mixer-side sample source for the four output paths
module ovsm_mixer_model #(
  parameter int PERIOD = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Random source
  input wire logic [31:0] rnd,
  // Samples
  output logic sample_valid,
  output logic signed [23:0] smp [4]
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      sample_valid <= 1'b0;
      smp <= '{default: 24'h000000};
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      sample_valid <= (cnt == PERIOD - 1);
      // Data toggles between samples so a stray capture is seen
      for (int p = 0; p < 4; p++) begin
        smp[p] <= (cnt == PERIOD - 1) ? 24'(signed'(rnd[4*p+:18])) : ~smp[p];
      end
    end
  end
endmodule // ovsm_mixer_model

// ==== tb/output_volume_softmute_path_bench.sv ====
// Self-checking bench for the output volume and soft mute block
`include "ovsm_consts.svh"
module output_volume_softmute_path_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ovsm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  // Seed 92568
  logic [31:0] rnd = 32'h00016998;
  logic [31:0] rd;
  logic [1:0] v;
  logic [7:0] mlvl [4];
  logic signed [23:0] cap [4];
  logic [13:0] ri [8] = '{`OVSM_IDX_FILT1, `OVSM_IDX_LC1, `OVSM_IDX_LC2, `OVSM_IDX_DAC_L,
    `OVSM_IDX_DAC_R, `OVSM_IDX_TX_L, `OVSM_IDX_TX_R, `OVSM_IDX_SOFTMUTE};
  logic [31:0] re [8] = '{32'h0, 32'h0, 32'h0, 32'h2C0, 32'h2C0, 32'h2C0, 32'h2C0, 32'h0};
  wire logic signed [23:0] din [4];
  wire logic signed [23:0] dout [4];
  wire logic [8:0] ctl;
  wire logic hreadyout;
  wire logic hresp;
  wire logic out_valid;
  wire logic sample_valid;
  wire logic [31:0] hrdata;
  int err_count = 0;
  int checks = 0;
  int scnt = 0;
  int n;

  always #10 hclk = ~hclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  always @(posedge hclk) begin
    rnd <= xs(rnd);
    if (sample_valid === 1'b1) begin
      scnt <= scnt + 1;
      cap <= din;
    end
  end

  ovsm_mixer_model #(.PERIOD(8)) ovsm_mixer_model_inst (.hclk(hclk), .hresetn(hresetn),
    .rnd(rnd), .sample_valid(sample_valid), .smp(din));
  ovsm_top #(.W(24)) ovsm_top_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sample_valid(sample_valid), .dac_left_in(din[0]), .dac_right_in(din[1]),
    .tx_two_left_in(din[2]), .tx_two_right_in(din[3]), .out_valid(out_valid),
    .dac_left_out(dout[0]), .dac_right_out(dout[1]), .tx_two_left_out(dout[2]),
    .tx_two_right_out(dout[3]), .record_one_quad_rate(ctl[0]),
    .rec_one_filter_bypass(ctl[1]), .rec_one_volume_bypass(ctl[2]),
    .play_one_level_ctrl_enable(ctl[3]), .rec_one_left_level_ctrl(ctl[4]),
    .rec_one_right_level_ctrl(ctl[5]), .play_two_level_ctrl_enable(ctl[6]),
    .rec_two_left_level_ctrl(ctl[7]), .rec_two_right_level_ctrl(ctl[8]));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("Checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang();
    err_count++;
    $display("[ERR] wait expected handshake seen timeout");
    stop_test();
  endtask

  task automatic rdy();
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) hang();
  endtask

  task automatic bus(input logic w, input logic [13:0] i, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {16'h0000, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic rdc(input logic [13:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    chk("reg", e, rd);
  endtask

  // Polls the applied level of one path; returns samples elapsed
  task automatic wlev(input int p, input logic [7:0] t, output int s);
    int k;
    int s0;
    s0 = scnt;
    k = 0;
    do begin
      bus(1'b0, `OVSM_IDX_STATUS, 32'h0);
      k++;
    end while (rd[8*p+:8] !== t && k < 3000);
    if (k >= 3000) hang();
    s = scnt - s0;
  endtask

  // Ramp time counted in samples, one code per tick
  task automatic ramp(input int p, input logic sp, input logic [7:0] c);
    int s;
    int d;
    logic [13:0] i;
    d = sp ? 32 : 2;
    i = 14'(`OVSM_IDX_DAC_L + p);
    bus(1'b1, `OVSM_IDX_SOFTMUTE, {30'h0, 1'b1, sp});
    bus(1'b1, i, {22'h0, 2'h3, c});
    wlev(p, 8'h00, s);
    bus(1'b1, i, {22'h0, 2'h0, c});
    wlev(p, c, s);
    chk("ramp_up", 32'h1, 32'(s >= (c - 1) * d && s <= (c + 1) * d + 2));
    bus(1'b1, i, {22'h0, 2'h2, c});
    wlev(p, 8'h00, s);
    chk("ramp_dn", 32'h1, 32'(s >= (c - 1) * d && s <= (c + 1) * d + 2));
  endtask

  task automatic samp(input int r);
    logic [31:0] e;
    repeat (r) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (out_valid !== 1'b1 && n < 50);
      if (n >= 50) hang();
      #1;
      for (int p = 0; p < 4; p++) begin
        e = (mlvl[p] == 8'h00) ? 32'h0 : (mlvl[p] == 8'hC0) ? 32'(cap[p]) : 32'(cap[p] * 4);
        chk("sample", e, 32'(dout[p]));
      end
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int k = 0; k < 8; k++) rdc(ri[k], re[k]);
    rdc(`OVSM_IDX_STATUS, 32'h0);
    chk("ctl", 32'h0, {23'h0, ctl});
    mlvl = '{8'h00, 8'h00, 8'h00, 8'h00};
    samp(2);
    bus(1'b1, 14'h0700, rnd);
    rdc(14'h0700, 32'h0);
    v = rnd[1:0];
    bus(1'b1, `OVSM_IDX_SOFTMUTE, {30'h0, v});
    rdc(`OVSM_IDX_SOFTMUTE, {30'h0, v});
    // Record placement only, then the quad-rate bit set in the filter register
    bus(1'b1, `OVSM_IDX_LC1, 32'h3);
    #1;
    chk("lc1", 32'h6, {29'h0, ctl[5:3]});
    bus(1'b1, `OVSM_IDX_FILT1, 32'h8000);
    #1;
    chk("quad", 32'h7, {29'h0, ctl[2:0]});
    chk("lc1q", 32'h0, {29'h0, ctl[5:3]});
    rdc(`OVSM_IDX_FILT1, 32'h8000);
    bus(1'b1, `OVSM_IDX_LC1, 32'h4);
    #1;
    chk("lc1p", 32'h1, {29'h0, ctl[5:3]});
    bus(1'b1, `OVSM_IDX_FILT1, 32'h0);
    #1;
    chk("quad", 32'h0, {29'h0, ctl[2:0]});
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, `OVSM_IDX_LC2, 32'(1 << k));
      #1;
      chk("lc2", 32'(4 >> k), {29'h0, ctl[8:6]});
    end
    ramp(0, 1'b0, 8'h10);
    ramp(1, 1'b0, 8'h40);
    ramp(2, 1'b1, 8'h08);
    ramp(3, 1'b0, 8'h20);
    bus(1'b1, `OVSM_IDX_SOFTMUTE, 32'h0);
    bus(1'b1, `OVSM_IDX_DAC_L, 32'h000000C0);
    bus(1'b1, `OVSM_IDX_DAC_R, 32'h00000100);
    bus(1'b1, `OVSM_IDX_TX_L, 32'h000001E0);
    bus(1'b1, `OVSM_IDX_TX_R, 32'h000001E8);
    repeat (2) @(posedge hclk);
    bus(1'b0, `OVSM_IDX_STATUS, 32'h0);
    chk("status", 32'h00E000C0, rd & 32'h00FFFFFF);
    mlvl = '{8'hC0, 8'h00, 8'hE0, 8'hE8};
    samp(4);
    bus(1'b1, `OVSM_IDX_TX_L, 32'h00000030);
    bus(1'b0, `OVSM_IDX_STATUS, 32'h0);
    chk("hold", 32'hE0, {24'h0, rd[23:16]});
    bus(1'b1, `OVSM_IDX_TX_R, 32'h00000150);
    repeat (2) @(posedge hclk);
    bus(1'b0, `OVSM_IDX_STATUS, 32'h0);
    chk("commit", 32'h5030, {16'h0, rd[31:16]});
    stop_test();
  end
endmodule // output_volume_softmute_path_bench
